// [dcrb_config_bank.sv]
`timescale 1ns/1ps
// Operation
// - Offset zero ignores writes, reads zero
// - Offset one holds output code, resets zero
// - Settings register resets to 0x0036
// - Fault after 1/2/4/8 consecutive check errors
// - Divide bit gives oscillator over 128
// - Clock pin toggles only when enabled, held low otherwise
// - Break-mode interrupt only when enabled
// - Interrupt pin active only when enabled
// - Enabled clear input forces clear state
// - Disable bit switches serial port off
// - Frame check only while check enabled
// - Interrupt polarity low default, high optional
// - Interrupt edge or sustained level
// - Tristate bit keeps data out floating
// - Early bit launches data on falling edge
module dcrb_config_bank
    import dcrb_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        sclk,
    input  wire logic        csN,
    input  wire logic        sdi,
    input  wire logic        clearPinN,
    input  wire logic        uartBreakMode,
    input  wire logic        irqEvent,
    input  wire logic        crcFaultClear,
    output logic             sdo,
    output logic             sdoOe,
    output logic [15:0]      outputCode,
    output logic             clockOutputPin,
    output logic             irqPin,
    output logic             irqPinOe,
    output logic             breakIrqReq,
    output logic             clearRequest,
    output logic             serialPortEnable,
    output logic             crcFault
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] crcStep(input logic [7:0] crc, input logic bitIn);
        logic fb;
        fb = crc[7] ^ bitIn;
        crcStep = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    endfunction : crcStep

    function automatic logic [15:0] readValue(input logic [6:0] ofs,
                                              input logic [15:0] code,
                                              input logic [15:0] cfg);
        unique case (ofs)
            NOOP_OFS:     readValue = NOOP_READ;
            CODE_OFS:     readValue = code;
            SETTINGS_OFS: readValue = (cfg & SETTINGS_WMASK) | SETTINGS_FIXED1;
            default:      readValue = 16'h0000;
        endcase
    endfunction : readValue

    ////////////////////////////////////////////////////////////////////////////
    dcrb_state_t st_reg;
    dcrb_state_t st_next;

    logic        sclkRise;
    logic        sclkFall;
    logic        csFall;
    logic        csRise;
    logic        csLow;
    logic        crcOn;
    logic [5:0]  frameLen;
    logic [3:0]  errLimit;
    logic        frameOk;
    logic        eventRise;
    logic [6:0]  frameOfs;
    logic [15:0] frameData;

    assign sclkRise  = st_reg.sync.sclk[1] & ~st_reg.sync.sclk[2];
    assign sclkFall  = ~st_reg.sync.sclk[1] & st_reg.sync.sclk[2];
    assign csFall    = ~st_reg.sync.csN[1] & st_reg.sync.csN[2];
    assign csRise    = st_reg.sync.csN[1] & ~st_reg.sync.csN[2];
    assign csLow     = ~st_reg.sync.csN[1];
    assign crcOn     = st_reg.settingsReg[CRC_EN_BIT];
    assign frameLen  = crcOn ? FRAME_BITS_CRC : FRAME_BITS;
    assign errLimit  = 4'(1) << st_reg.settingsReg[FCF_THR_HI:FCF_THR_LO];
    assign eventRise = irqEvent & ~st_reg.eventPrev;

    // Received word is right-aligned; with the check byte on, header sits 8 higher
    assign frameOfs  = crcOn ? st_reg.rxShift[30:24] : st_reg.rxShift[22:16];
    assign frameData = crcOn ? st_reg.rxShift[23:8]  : st_reg.rxShift[15:0];
    // Check over all bits including the trailing byte leaves zero when good
    assign frameOk   = (st_reg.bitCnt == frameLen) &&
                       (!crcOn || st_reg.crcAcc == 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_next = st_reg;

        // Pins are asynchronous to sys_clk
        st_next.sync.sclk = {st_reg.sync.sclk[1:0], sclk};
        st_next.sync.csN  = {st_reg.sync.csN[1:0], csN};
        st_next.sync.sdi  = {st_reg.sync.sdi[0], sdi};
        st_next.sync.clrN = {st_reg.sync.clrN[0], clearPinN};

        //////////////////////////////////////////////////////////////////////
        // Serial receive and transmit
        if (csFall)
        begin
            st_next.bitCnt  = 6'd0;
            st_next.crcAcc  = CRC_INIT;
            // Early launch: the leading zero is already on the line, so start one bit on
            if (st_reg.settingsReg[SDO_EARLY_BIT])
                st_next.txShift = {st_reg.readOfs, st_reg.readWord, 9'h000};
            else
                st_next.txShift = {1'b0, st_reg.readOfs, st_reg.readWord, 8'h00};
            st_next.sdo     = 1'b0;
        end
        else if (csLow)
        begin
            if (sclkRise)
            begin
                st_next.rxShift = {st_reg.rxShift[30:0], st_reg.sync.sdi[1]};
                st_next.crcAcc  = crcStep(st_reg.crcAcc, st_reg.sync.sdi[1]);
                if (st_reg.bitCnt != FRAME_BITS_CRC)
                    st_next.bitCnt = st_reg.bitCnt + 6'd1;
            end
            // Launch edge picks when the next bit leaves
            if (st_reg.settingsReg[SDO_EARLY_BIT] ? sclkFall : sclkRise)
            begin
                st_next.sdo     = st_reg.txShift[31];
                st_next.txShift = {st_reg.txShift[30:0], 1'b0};
            end
        end

        // Frame is acted on only once complete, at chip-select release
        if (csRise)
        begin
            if (frameOk)
            begin
                st_next.errRun = 4'd0;
                if (crcOn ? st_reg.rxShift[31] : st_reg.rxShift[READ_BIT])
                begin
                    st_next.readOfs  = frameOfs;
                    st_next.readWord = readValue(frameOfs, st_reg.codeReg,
                                                 st_reg.settingsReg);
                end
                else
                begin
                    unique case (frameOfs)
                        CODE_OFS:     st_next.codeReg = frameData;
                        SETTINGS_OFS: st_next.settingsReg =
                            (frameData & SETTINGS_WMASK) | SETTINGS_FIXED1;
                        default:      st_next.codeReg = st_reg.codeReg;
                    endcase
                end
            end
            else if (crcOn && st_reg.bitCnt == frameLen)
            begin
                // Consecutive bad frames; saturate so the count cannot wrap
                if (st_reg.errRun != 4'hf)
                    st_next.errRun = st_reg.errRun + 4'd1;
                if (st_reg.errRun + 4'd1 >= errLimit)
                    st_next.crcFault = 1'b1;
            end
        end

        // Clear loses to a fault set in the same cycle
        if (crcFaultClear && !(st_next.crcFault && !st_reg.crcFault))
            st_next.crcFault = 1'b0;

        //////////////////////////////////////////////////////////////////////
        // Clock output
        if (st_reg.oscCnt == OSC_HALF_LAST)
        begin
            st_next.oscCnt   = 8'd0;
            st_next.oscLevel = ~st_reg.oscLevel;
            if (st_reg.oscLevel)
                st_next.divCnt = st_reg.divCnt + 1'b1;
        end
        else
            st_next.oscCnt = st_reg.oscCnt + 8'd1;
        if (!st_reg.settingsReg[CLK_EN_BIT])
            st_next.clkOut = 1'b0;
        else if (st_reg.settingsReg[CLK_DIV_BIT])
            st_next.clkOut = st_reg.divCnt[DIV_MSB];
        else
            st_next.clkOut = st_reg.oscLevel;

        //////////////////////////////////////////////////////////////////////
        // Interrupt shaping
        st_next.eventPrev = irqEvent;
        if (st_reg.settingsReg[INTERRUPT_LEVEL_SELECT_BIT])
        begin
            st_next.irqHold   = 8'd0;
            st_next.irqActive = irqEvent;
        end
        else if (eventRise)
        begin
            // Edge mode: a fixed-width pulse per new event
            st_next.irqHold   = IRQ_EDGE_CYC;
            st_next.irqActive = 1'b1;
        end
        else if (st_reg.irqHold > 8'd1)
            st_next.irqHold = st_reg.irqHold - 8'd1;
        else
        begin
            st_next.irqHold   = 8'd0;
            st_next.irqActive = 1'b0;
        end

        st_next.breakIrq = eventRise && uartBreakMode &&
                           st_reg.settingsReg[BRK_IRQ_BIT] &&
                           !st_reg.settingsReg[SER_DIS_BIT];

        //////////////////////////////////////////////////////////////////////
        // Clear input: data-in pin doubles as clear in break mode
        st_next.clearReq = st_reg.settingsReg[CLR_EN_BIT] &&
                           (uartBreakMode ? ~st_reg.sync.sdi[1]
                                          : ~st_reg.sync.clrN[1]);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg             <= '0;
            st_reg.sync.sclk   <= 3'h0;
            st_reg.sync.csN    <= 3'h7;
            st_reg.sync.sdi    <= 2'h3;
            st_reg.sync.clrN   <= 2'h3;
            st_reg.codeReg     <= CODE_RESET;
            st_reg.settingsReg <= SETTINGS_RESET;
            st_reg.crcAcc      <= CRC_INIT;
        end
        else
            st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    assign sdo              = st_reg.sdo;
    assign sdoOe            = ~st_reg.settingsReg[SDO_TRI_BIT] && csLow;
    assign outputCode       = st_reg.codeReg;
    assign clockOutputPin   = st_reg.clkOut;
    assign irqPin           = st_reg.irqActive ^ ~st_reg.settingsReg[INTERRUPT_POLARITY_BIT];
    assign irqPinOe         = st_reg.settingsReg[IRQ_PIN_BIT];
    assign breakIrqReq      = st_reg.breakIrq;
    assign clearRequest     = st_reg.clearReq;
    assign serialPortEnable = ~st_reg.settingsReg[SER_DIS_BIT];
    assign crcFault         = st_reg.crcFault;

endmodule : dcrb_config_bank

// [dcrb_config_bank_props.sv]
`timescale 1ns/1ps
module dcrb_config_bank_props (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        csN,
    input wire logic        sdi,
    input wire logic        clearPinN,
    input wire logic        uartBreakMode,
    input wire logic        crcFaultClear,
    input wire logic        sdoOe,
    input wire logic [15:0] outputCode,
    input wire logic        clockOutputPin,
    input wire logic        irqPinOe,
    input wire logic        breakIrqReq,
    input wire logic        clearRequest,
    input wire logic        serialPortEnable,
    input wire logic        crcFault
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // Settings and code only move once a frame has closed
    property p_sdo_idle; csN[*5] |-> !sdoOe; endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven while deselected");
    property p_code_frame; $changed(outputCode) |-> csN; endproperty
    a_code_frame: assert property (p_code_frame) else $error("code changed in frame");
    property p_fault_frame; $rose(crcFault) |-> csN; endproperty
    a_fault_frame: assert property (p_fault_frame) else $error("fault set in frame");
    property p_fault_sticky; $fell(crcFault) |-> $past(crcFaultClear); endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault dropped alone");
    // Settings land a few cycles after select rises and may cut a half period
    property p_clk_half;
        csN[*8] ##0 $changed(clockOutputPin) |=> $stable(clockOutputPin)[*8];
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("clock half period short");
    property p_oe_frame; $changed(irqPinOe) |-> csN; endproperty
    a_oe_frame: assert property (p_oe_frame) else $error("irq enable moved in frame");
    property p_uart_frame; $changed(serialPortEnable) |-> csN; endproperty
    a_uart_frame: assert property (p_uart_frame) else $error("uart enable moved");
    property p_brk_pulse; breakIrqReq |-> uartBreakMode ##1 !breakIrqReq; endproperty
    a_brk_pulse: assert property (p_brk_pulse) else $error("break request malformed");
    property p_clr_cause; (clearPinN && sdi)[*6] |-> !$rose(clearRequest); endproperty
    a_clr_cause: assert property (p_clr_cause) else $error("clear without pin");
endmodule : dcrb_config_bank_props

bind dcrb_config_bank dcrb_config_bank_props i_props (.*);

// [dcrb_host.sv]
`timescale 1ns/1ps
module dcrb_host (
    input  wire logic sys_clk,
    input  wire logic sdoLine,
    output logic      sclk,
    output logic      csN,
    output logic      sdi
);
    logic crcOn = 1'b1;

    initial
    begin
        {sclk, csN, sdi} = 3'b010;
    end

    // Sampling late in the high phase covers the launch delay of the sync stages
    task automatic frame(input logic [23:0] w, input logic bad, output logic [15:0] rd);
        logic [31:0] f, r;
        logic [7:0]  c;
        c = 8'hff;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        f = {w, c ^ {7'h0, bad}};
        @(negedge sys_clk) csN = 0;
        for (int i = 31; i >= (crcOn ? 0 : 8); i--)
        begin
            sdi = f[i];
            repeat (6) @(negedge sys_clk);
            sclk = 1;
            repeat (6) @(negedge sys_clk);
            r = {r[30:0], sdoLine};
            sclk = 0;
        end
        repeat (6) @(negedge sys_clk);
        csN = 1;
        sdi = ~sdi;
        repeat (8) @(negedge sys_clk);
        rd = crcOn ? r[23:8] : r[15:0];
    endtask : frame
endmodule : dcrb_host

// [dcrb_pkg.sv]
package dcrb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [6:0]  NOOP_OFS        = 7'h00;
    localparam logic [6:0]  CODE_OFS        = 7'h01;
    localparam logic [6:0]  SETTINGS_OFS    = 7'h02;
    localparam logic [15:0] NOOP_READ       = 16'h0000;
    localparam logic [15:0] CODE_RESET      = 16'h0000;
    localparam logic [15:0] SETTINGS_RESET  = 16'h0036;
    localparam logic [15:0] SETTINGS_WMASK  = 16'h7bdf;
    localparam logic [15:0] SETTINGS_FIXED1 = 16'h0020;

    // Field positions in the settings register
    localparam int FCF_THR_HI   = 14;
    localparam int FCF_THR_LO   = 13;
    localparam int CLK_DIV_BIT  = 12;
    localparam int CLK_EN_BIT   = 11;
    localparam int BRK_IRQ_BIT  = 9;
    localparam int IRQ_PIN_BIT  = 8;
    localparam int CLR_EN_BIT   = 7;
    localparam int SER_DIS_BIT  = 6;
    localparam int CRC_EN_BIT   = 4;
    localparam int INTERRUPT_POLARITY_BIT  = 3;
    localparam int INTERRUPT_LEVEL_SELECT_BIT  = 2;
    localparam int SDO_TRI_BIT  = 1;
    localparam int SDO_EARLY_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame: read flag, 7-bit offset, 16-bit data, optional 8-bit check
    localparam logic [5:0]  FRAME_BITS      = 6'd24;
    localparam logic [5:0]  FRAME_BITS_CRC  = 6'd32;
    localparam int          READ_BIT        = 23;
    localparam logic [7:0]  CRC_POLY        = 8'h07;
    localparam logic [7:0]  CRC_INIT        = 8'hff;
    localparam logic [31:0] SDO_IDLE_WORD   = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          SYS_CLK_KHZ     = 200000;
    localparam int          OSC_HZ          = 1228800;
    localparam int          OSC_HALF_CYC    = (SYS_CLK_KHZ * 1000) / (2 * OSC_HZ);
    localparam logic [7:0]  OSC_HALF_LAST   = 8'(OSC_HALF_CYC - 1);
    localparam int          OUT_DIVIDE      = 128;
    localparam int          DIV_MSB         = $clog2(OUT_DIVIDE) - 1;
    localparam int          IRQ_EDGE_NS     = 1000;
    localparam int          SYS_CLK_NS      = 5;
    localparam logic [7:0]  IRQ_EDGE_CYC    = 8'(IRQ_EDGE_NS / SYS_CLK_NS);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0] sclk;
        logic [2:0] csN;
        logic [1:0] sdi;
        logic [1:0] clrN;
    } dcrb_sync_t;

    typedef struct packed {
        dcrb_sync_t  sync;
        logic [31:0] rxShift;
        logic [31:0] txShift;
        logic [5:0]  bitCnt;
        logic [7:0]  crcAcc;
        logic [15:0] readWord;
        logic [6:0]  readOfs;
        logic [15:0] codeReg;
        logic [15:0] settingsReg;
        logic [3:0]  errRun;
        logic        crcFault;
        logic        sdo;
        logic [7:0]  oscCnt;
        logic        oscLevel;
        logic [DIV_MSB:0] divCnt;
        logic        clkOut;
        logic        eventPrev;
        logic [7:0]  irqHold;
        logic        irqActive;
        logic        breakIrq;
        logic        clearReq;
    } dcrb_state_t;

endpackage : dcrb_pkg

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
    import dcrb_pkg::*;
    logic        sys_clk, nrst, sclk, csN, sdi, clearPinN, uartBreakMode, irqEvent;
    logic        crcFaultClear, sdo, sdoOe, clockOutputPin, irqPin, irqPinOe, flip;
    logic        breakIrqReq, clearRequest, serialPortEnable, crcFault, sdoLine;
    logic [15:0] outputCode, rdat;
    int          n_errors = 0, total_checks = 0, n;

    dcrb_config_bank i_dut (.*);
    dcrb_host i_host (.sys_clk(sys_clk), .sdoLine(sdoLine), .sclk(sclk), .csN(csN), .sdi(sdi));

    // Undriven line wanders so a stale level never passes as data
    assign sdoLine = sdoOe ? sdo : flip;
    initial
    begin
        {sys_clk, flip} = 2'b00;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) flip <= ~flip;

    ////////////////////////////////////////////////////////////////////////////
    task wr(input logic [6:0] a, input logic [15:0] d);
        i_host.frame({1'b0, a, d}, 1'b0, rdat);
    endtask : wr
    task cfg(input logic [15:0] v);
        wr(SETTINGS_OFS, v | SETTINGS_FIXED1);
    endtask : cfg
    task rd(input logic [6:0] a);
        i_host.frame({1'b1, a, 16'h0000}, 1'b0, rdat);
        i_host.frame({1'b1, NOOP_OFS, 16'h0000}, 1'b0, rdat);
    endtask : rd
    task t_reset;
        `CHK("code", CODE_RESET, outputCode)
        `CHK("clkpin", 1'b0, clockOutputPin)
        `CHK("irqoe", 1'b0, irqPinOe)
        `CHK("irqpin", 1'b1, irqPin)
        `CHK("uarten", 1'b1, serialPortEnable)
        `CHK("sdooe", 1'b0, sdoOe)
    endtask : t_reset
    task t_regs;
        wr(CODE_OFS, 16'ha5c3);
        `CHK("code", 16'ha5c3, outputCode)
        cfg(16'h8414);
        rd(SETTINGS_OFS);
        `CHK("settings", 16'h0034, rdat)
        wr(NOOP_OFS, 16'hffff);
        `CHK("code", 16'ha5c3, outputCode)
        rd(NOOP_OFS);
        `CHK("noop", NOOP_READ, rdat)
        rd(CODE_OFS);
        `CHK("coderd", 16'ha5c3, rdat)
        cfg(16'h0015);
        rd(CODE_OFS);
        `CHK("fastrd", 16'ha5c3, rdat)
    endtask : t_regs
    task t_irq;
        cfg(16'h011c);
        irqEvent = 1;
        repeat (3) @(negedge sys_clk);
        `CHK("irqoe", 1'b1, irqPinOe)
        `CHK("irqhi", 1'b1, irqPin)
        irqEvent = 0;
        repeat (3) @(negedge sys_clk);
        `CHK("irqlo", 1'b0, irqPin)
        cfg(16'h0110);
        irqEvent = 1;
        repeat (100) @(negedge sys_clk);
        `CHK("edge", 1'b0, irqPin)
        repeat (200) @(negedge sys_clk);
        `CHK("edgeend", 1'b1, irqPin)
        irqEvent = 0;
    endtask : t_irq
    task half(input int e);
        logic v;
        // First span may be partial after a mode switch
        repeat (3)
        begin
            n = 0;
            v = clockOutputPin;
            while (clockOutputPin === v && n < 20000)
            begin
                @(negedge sys_clk);
                n++;
            end
        end
        `CHK("half", e, n)
    endtask : half
    task t_clk;
        cfg(16'h0814);
        half(81);
        cfg(16'h1814);
        half(81 * 128);
        cfg(16'h0014);
        repeat (20) @(negedge sys_clk);
        `CHK("clkoff", 1'b0, clockOutputPin)
    endtask : t_clk
    task t_misc;
        cfg(16'h0054);
        `CHK("uarten", 1'b0, serialPortEnable)
        cfg(16'h0094);
        clearPinN = 0;
        repeat (8) @(negedge sys_clk);
        `CHK("clear", 1'b1, clearRequest)
        clearPinN = 1;
        uartBreakMode = 1;
        for (int k = 0; k < 2; k++)
        begin
            irqEvent = 0;
            cfg(k ? 16'h0014 : 16'h0214);
            n = 0;
            irqEvent = 1;
            repeat (10) @(negedge sys_clk) n += breakIrqReq;
            `CHK("brk", k ? 0 : 1, n)
        end
        {irqEvent, uartBreakMode} = 2'b00;
    endtask : t_misc
    task t_crc;
        for (int k = 0; k < 4; k++)
        begin
            cfg({1'b0, 2'(k), 13'h0014});
            repeat ((1 << k) - 1) i_host.frame({1'b0, CODE_OFS, 16'h5a5a}, 1'b1, rdat);
            `CHK("early", 1'b0, crcFault)
            i_host.frame({1'b0, CODE_OFS, 16'h5a5a}, 1'b1, rdat);
            `CHK("fault", 1'b1, crcFault)
            `CHK("badwr", 16'ha5c3, outputCode)
            crcFaultClear = 1;
            @(negedge sys_clk) crcFaultClear = 0;
            @(negedge sys_clk);
            `CHK("clr", 1'b0, crcFault)
        end
        cfg(16'h0004);
        i_host.crcOn = 0;
        wr(CODE_OFS, 16'h1234);
        `CHK("nocrc", 16'h1234, outputCode)
    endtask : t_crc
    task final_report;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {nrst, clearPinN, uartBreakMode, irqEvent, crcFaultClear} = 5'b01000;
        repeat (4) @(negedge sys_clk);
        nrst = 1;
        repeat (4) @(negedge sys_clk);
        t_reset;
        t_regs;
        t_irq;
        t_clk;
        t_misc;
        t_crc;
        final_report;
    end
    initial
    begin
        #500us;
        n_errors++;
        final_report;
    end
endmodule : testbench
